// file: shared/ioe_pkg.sv
// Constants, field layouts, reset values and phase codes for the 16-bit
// I/O expander serial target. Assumes one design file imports nothing and
// refers to every name as ioe_pkg::name.
package ioe_pkg;

  // Port geometry
  localparam int PORT_W = 8;
  localparam int PIN_N = 16;

  // Address byte layout
  localparam logic [3:0] ADDR_FIXED = 4'h4;
  localparam logic [6:0] GEN_CALL = 7'h00;

  // Bit counter positions within one byte frame
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Command byte register selects, bits [2:1]
  localparam logic [1:0] SEL_IN = 2'h0;
  localparam logic [1:0] SEL_OUT = 2'h1;
  localparam logic [1:0] SEL_POL = 2'h2;
  localparam logic [1:0] SEL_CFG = 2'h3;

  // Reset values
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] OUT_RST = 8'hFF;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'hFF;

  // Clock edges after reset release before synchronised pins are real
  localparam logic [1:0] INIT_WAIT = 2'h2;

  // Command value under which a foreign read clears port 0
  localparam logic [7:0] DEFECT_CMD = 8'h00;

  // Transfer phases of the link side
  typedef enum logic [2:0] {
    PH_ADDR = 3'b000,
    PH_CMD = 3'b001,
    PH_WDATA = 3'b010,
    PH_RDATA = 3'b011,
    PH_SKIP = 3'b100
  } ioe_phase_t;

endpackage

// file: verilog/ioe_i2c_target.sv
// Serial target of a 16-bit I/O expander with change alert.
// Assumes SCL is the link clock port, SDA and the alert are open-drain pins
// resolved outside, and rst_n is the power-on reset of the whole device.
`timescale 1ns/1ns

module ioe_i2c_target (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [2:0] addrSelectPins,
  input wire logic [15:0] ioIn,
  output logic [15:0] ioOut,
  output logic [15:0] ioOe,
  output logic intOut,
  output logic intOe
);

  // ---- Link domain state (SCL) ----
  // Registers below change on SCL edges; framing ones also clear on linkRstN
  ioe_pkg::ioe_phase_t phase, next_phase;
  logic [3:0] bitCnt, next_bitCnt;
  logic [7:0] shiftReg, next_shiftReg;
  logic [7:0] txByte, next_txByte;
  logic ackReq, next_ackReq;
  logic readBusy, next_readBusy;
  logic [7:0] cmdByte, next_cmdByte;
  logic [1:0][7:0] outReg, next_outReg;
  logic [1:0][7:0] polReg, next_polReg;
  logic [1:0][7:0] cfgReg, next_cfgReg;
  logic wrTgl, next_wrTgl;
  logic [1:0] clrTgl, next_clrTgl;
  logic next_sdaOe;
  logic [7:0] rxByte;
  logic addrHit;
  logic [7:0] readVal;

  // ---- System domain state (clk) ----
  // Events from the link arrive as toggles and pass three flops
  logic [15:0] pinS1, pinS2;
  logic sclS1, sclS2, sclS3;
  logic sdaS1, sdaS2, sdaS3;
  logic [2:0] selS1, selS2;
  logic busyS1, busyS2;
  logic wrS1, wrS2, wrS3;
  logic [1:0] clrS1, clrS2, clrS3;
  logic linkRstN, next_linkRstN;
  logic relPend, next_relPend;
  logic initDone, next_initDone;
  // Counts edges until both synchroniser stages hold real pin levels
  logic [1:0] initCnt, next_initCnt;
  logic [15:0] snapIn, next_snapIn;
  logic [15:0] refIn, next_refIn;
  logic [15:0] next_ioOut, next_ioOe;
  logic next_intOe;
  logic startSeen, stopSeen, wrEdge;
  logic [1:0] clrEdge;

  // ===================== System domain =====================

  // Two-flop synchronisers for pins and link-side events
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinS1 <= 16'h0000;
      pinS2 <= 16'h0000;
      sclS1 <= 1'b1;
      sclS2 <= 1'b1;
      sclS3 <= 1'b1;
      sdaS1 <= 1'b1;
      sdaS2 <= 1'b1;
      sdaS3 <= 1'b1;
      selS1 <= 3'h0;
      selS2 <= 3'h0;
      busyS1 <= 1'b0;
      busyS2 <= 1'b0;
      wrS1 <= 1'b0;
      wrS2 <= 1'b0;
      wrS3 <= 1'b0;
      clrS1 <= 2'h0;
      clrS2 <= 2'h0;
      clrS3 <= 2'h0;
    end else if (ce) begin
      pinS1 <= ioIn;
      pinS2 <= pinS1;
      sclS1 <= scl;
      sclS2 <= sclS1;
      sclS3 <= sclS2;
      sdaS1 <= sdaIn;
      sdaS2 <= sdaS1;
      sdaS3 <= sdaS2;
      selS1 <= addrSelectPins; // Quasi-static during a transfer
      selS2 <= selS1;
      busyS1 <= readBusy;
      busyS2 <= busyS1;
      wrS1 <= wrTgl;
      wrS2 <= wrS1;
      wrS3 <= wrS2;
      clrS1 <= clrTgl;
      clrS2 <= clrS1;
      clrS3 <= clrS2;
    end
  end

  // Bus conditions seen with SCL steady high
  assign startSeen = sclS2 & sclS3 & sdaS3 & ~sdaS2;
  assign stopSeen = sclS2 & sclS3 & ~sdaS3 & sdaS2;
  // Each toggle flips once per event, so a two-flop pass is safe
  // as long as events are far apart compared with the clk period
  assign wrEdge = wrS3 ^ wrS2;
  assign clrEdge = clrS3 ^ clrS2;

  // Next values of link reset, input tracking, pin drive and alert
  always_comb begin
    next_linkRstN = linkRstN;
    next_relPend = relPend;
    if (startSeen) begin
      // Pulse the link reset so a repeated start also restarts framing
      next_linkRstN = 1'b0;
      next_relPend = 1'b1;
    end else if (relPend) begin
      next_linkRstN = 1'b1;
      next_relPend = 1'b0;
    end else if (stopSeen) begin
      next_linkRstN = 1'b0; // Link logic idles until the next start
    end
    // Reference must not load the synchronisers' reset value
    next_initCnt = initCnt;
    if (initCnt != ioe_pkg::INIT_WAIT) begin
      next_initCnt = initCnt + 2'h1;
    end
    next_initDone = initDone | (initCnt == ioe_pkg::INIT_WAIT);
    // Input snapshot stays frozen while a read may be shifting it out
    next_snapIn = busyS2 ? snapIn : pinS2;
    next_refIn = refIn;
    if (!initDone) begin
      next_refIn = pinS2; // Reference caught after power-on release
    end else begin
      for (int p = 0; p < 2; p++) begin
        // Each port re-arms on its own read; port 0 also on a foreign read acked under command 00h
        if (clrEdge[p]) begin
          next_refIn[p*8 +: 8] = pinS2[p*8 +: 8];
        end
      end
    end
    next_ioOut = ioOut;
    next_ioOe = ioOe;
    if (wrEdge) begin
      next_ioOut = {outReg[1], outReg[0]};
      next_ioOe = ~{cfgReg[1], cfgReg[0]};
    end
    // Alert while an input pin differs from its reference level
    next_intOe = initDone & (|((pinS2 ^ refIn) & ~ioOe));
  end

  // Register the system domain state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkRstN <= 1'b0;
      relPend <= 1'b0;
      initDone <= 1'b0;
      initCnt <= 2'h0;
      snapIn <= 16'h0000;
      refIn <= 16'h0000;
      ioOut <= {ioe_pkg::OUT_RST, ioe_pkg::OUT_RST};
      ioOe <= 16'h0000; // All pins inputs
      intOe <= 1'b0;
      intOut <= 1'b0;
      sdaOut <= 1'b0;
    end else if (ce) begin
      linkRstN <= next_linkRstN;
      relPend <= next_relPend;
      initDone <= next_initDone;
      initCnt <= next_initCnt;
      snapIn <= next_snapIn;
      refIn <= next_refIn;
      ioOut <= next_ioOut;
      ioOe <= next_ioOe;
      intOe <= next_intOe; // Open drain, only pulls low
      intOut <= 1'b0;
      sdaOut <= 1'b0; // SDA is only ever pulled low
    end
  end

  // ===================== Link domain =====================

  // Received byte including the bit on the current rising edge
  assign rxByte = {shiftReg[6:0], sdaIn}; // MSB first
  assign addrHit = (rxByte[7:1] == {ioe_pkg::ADDR_FIXED, selS2})
    && (rxByte[7:1] != ioe_pkg::GEN_CALL);

  // Byte returned for the current command
  // Input reads use the frozen snapshot so bits cannot tear mid-byte
  always_comb begin
    readVal = 8'h00;
    unique case (cmdByte[2:1])
      ioe_pkg::SEL_IN: begin
        readVal = snapIn[cmdByte[0]*8 +: 8] ^ polReg[cmdByte[0]];
      end
      ioe_pkg::SEL_OUT: begin
        readVal = outReg[cmdByte[0]];
      end
      ioe_pkg::SEL_POL: begin
        readVal = polReg[cmdByte[0]];
      end
      ioe_pkg::SEL_CFG: begin
        readVal = cfgReg[cmdByte[0]];
      end
    endcase
  end

  // Next values on each rising SCL edge
  always_comb begin
    next_phase = phase;
    next_bitCnt = bitCnt;
    next_shiftReg = shiftReg;
    next_txByte = txByte;
    next_ackReq = ackReq;
    next_readBusy = readBusy;
    next_cmdByte = cmdByte;
    next_outReg = outReg;
    next_polReg = polReg;
    next_cfgReg = cfgReg;
    next_wrTgl = wrTgl;
    next_clrTgl = clrTgl;
    if (bitCnt != ioe_pkg::ACK_SLOT) begin
      // Data bit: sample on the rising edge
      next_shiftReg = rxByte;
      next_bitCnt = bitCnt + 4'h1;
      if (bitCnt == ioe_pkg::BIT_LAST) begin
        next_ackReq = 1'b0;
        unique case (phase)
          ioe_pkg::PH_ADDR: begin
            if (addrHit) begin
              next_ackReq = 1'b1;
              next_readBusy = rxByte[0]; // Direction 1 is read
            end
          end
          ioe_pkg::PH_CMD: begin
            next_ackReq = 1'b1;
            next_cmdByte = rxByte;
          end
          ioe_pkg::PH_WDATA: begin
            next_ackReq = 1'b1;
            next_wrTgl = ~wrTgl;
            unique case (cmdByte[2:1])
              ioe_pkg::SEL_IN: begin
                next_wrTgl = wrTgl; // Input registers ignore writes
              end
              ioe_pkg::SEL_OUT: begin
                next_outReg[cmdByte[0]] = rxByte;
              end
              ioe_pkg::SEL_POL: begin
                next_polReg[cmdByte[0]] = rxByte;
              end
              ioe_pkg::SEL_CFG: begin
                next_cfgReg[cmdByte[0]] = rxByte;
              end
            endcase
          end
          ioe_pkg::PH_RDATA, ioe_pkg::PH_SKIP: begin
            next_ackReq = 1'b0;
          end
        endcase
      end
    end else begin
      // Acknowledge slot, rising edge
      next_bitCnt = 4'h0;
      next_ackReq = 1'b0;
      unique case (phase)
        ioe_pkg::PH_ADDR: begin
          if (ackReq && shiftReg[0]) begin
            next_phase = ioe_pkg::PH_RDATA;
            next_txByte = readVal;
          end else if (ackReq) begin
            next_phase = ioe_pkg::PH_CMD;
          end else begin
            next_phase = ioe_pkg::PH_SKIP; // Other target: ignored, except the port 0 clear below
            // Foreign read acked while command is 00h clears port 0
            if (shiftReg[0] && !sdaIn
                && cmdByte == ioe_pkg::DEFECT_CMD) begin
              next_clrTgl[0] = ~clrTgl[0];
            end
          end
        end
        ioe_pkg::PH_CMD: begin
          next_phase = ioe_pkg::PH_WDATA;
        end
        ioe_pkg::PH_WDATA: begin
          next_phase = ioe_pkg::PH_WDATA;
        end
        ioe_pkg::PH_RDATA: begin
          // Ack or nack of an input port read byte clears its port
          if (cmdByte[2:1] == ioe_pkg::SEL_IN) begin
            next_clrTgl[cmdByte[0]] = ~clrTgl[cmdByte[0]];
          end
          if (sdaIn) begin
            next_phase = ioe_pkg::PH_SKIP; // Nack ends the read
          end else begin
            next_txByte = readVal;
          end
        end
        ioe_pkg::PH_SKIP: begin
          next_phase = ioe_pkg::PH_SKIP;
        end
      endcase
    end
  end

  // Framing state, cleared by stop and pulsed by start
  // A start pulses linkRstN low, so framing restarts at bit 0
  always_ff @(posedge scl or negedge linkRstN) begin
    if (!linkRstN) begin
      phase <= ioe_pkg::PH_ADDR;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      txByte <= 8'h00;
      ackReq <= 1'b0;
      readBusy <= 1'b0;
    end else begin
      phase <= next_phase;
      bitCnt <= next_bitCnt;
      shiftReg <= next_shiftReg;
      txByte <= next_txByte;
      ackReq <= next_ackReq;
      readBusy <= next_readBusy;
    end
  end

  // Register file and event toggles survive stop, reset only at power-on
  // Stop and start leave them alone so the pointer persists between reads
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      cmdByte <= ioe_pkg::CMD_RST;
      outReg <= {ioe_pkg::OUT_RST, ioe_pkg::OUT_RST};
      polReg <= {ioe_pkg::POL_RST, ioe_pkg::POL_RST};
      cfgReg <= {ioe_pkg::CFG_RST, ioe_pkg::CFG_RST};
      wrTgl <= 1'b0;
      clrTgl <= 2'h0;
    end else begin
      cmdByte <= next_cmdByte;
      outReg <= next_outReg;
      polReg <= next_polReg;
      cfgReg <= next_cfgReg;
      wrTgl <= next_wrTgl;
      clrTgl <= next_clrTgl;
    end
  end

  // SDA drive decided for the coming low phase
  always_comb begin
    next_sdaOe = 1'b0;
    if (bitCnt == ioe_pkg::ACK_SLOT) begin
      next_sdaOe = ackReq; // Low through the ack high phase
    end else if (phase == ioe_pkg::PH_RDATA) begin
      next_sdaOe = ~txByte[~bitCnt[2:0]]; // MSB first
    end
  end

  // SDA changes on falling SCL, and is also released when linkRstN falls
  // Moving SDA there keeps it steady through the high phase,
  // so the target never forms a false start or stop
  always_ff @(negedge scl or negedge linkRstN) begin
    if (!linkRstN) begin
      sdaOe <= 1'b0; // Released at stop
    end else begin
      sdaOe <= next_sdaOe;
    end
  end

endmodule // ioe_i2c_target

// file: verif/ioe_mst.sv
// Bus master model: drives the link clock and pulls SDA low.
// Assumes the bench resolves SDA from every open-drain enable.
`timescale 1ns/1ns

module ioe_mst (
  output logic scl,
  output logic sdaOe,
  input wire logic sda
);
  localparam int HALF = 24;

  // Link clock stands high and SDA released outside frames
  initial begin
    scl = 1'b1;
    sdaOe = 1'b0;
  end

  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    sdaOe = 1'b0;
    #HALF scl = 1'b1;
    #HALF sdaOe = 1'b1;
    #(3*HALF) scl = 1'b0;
  endtask

  // Stop: SDA rises while SCL is high
  task automatic stop();
    sdaOe = 1'b1;
    #HALF scl = 1'b1;
    #(2*HALF) sdaOe = 1'b0;
    #HALF;
  endtask

  // One bit: SDA moves while SCL is low, sampled at the rising edge
  task automatic bit_io(input logic b, output logic r);
    sdaOe = !b;
    #HALF scl = 1'b1;
    r = sda;
    #HALF scl = 1'b0;
  endtask

  // Byte out MSB first; fake lets another target pull the ack low
  task automatic send(input logic [7:0] d, input logic fake,
                      output logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(!fake, r);
    ok = !r;
  endtask

  // Byte in MSB first; last byte gets a nack
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // ioe_mst

// file: verif/ioe_chk.sv
// Port checker for the expander target, bound to its top module.
// Assumes one system clock domain for all sampled relations.
`timescale 1ns/1ns

module ioe_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [15:0] ioIn,
  input wire logic [15:0] ioOut,
  input wire logic [15:0] ioOe,
  input wire logic intOut,
  input wire logic intOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // No alert, inputs and directions steady
  sequence s_quiet;
    (!intOe && $stable(ioIn & ~ioOe) && $stable(ioOe))[*4];
  endsequence

  // Properties
  property p_rstval;
    $rose(rst_n) |-> ioOe == 16'h0000 && ioOut == 16'hFFFF && !intOe;
  endproperty
  property p_sdaod;
    sdaOut == 1'b0;
  endproperty
  property p_intod;
    intOut == 1'b0;
  endproperty
  property p_quiet;
    s_quiet ##1 ($stable(ioIn & ~ioOe) && $stable(ioOe)) |-> !intOe;
  endproperty
  property p_rise;
    s_quiet ##1 !$stable(ioIn & ~ioOe) |-> ##[1:4] intOe;
  endproperty
  property p_stay;
    (intOe && scl && $stable(ioIn) && $stable(ioOe))[*6] |=> intOe;
  endproperty
  property p_edge;
    $changed(sdaOe) |-> !scl;
  endproperty
  property p_sdahi;
    scl && $past(scl) |-> $stable(sdaOe);
  endproperty

  // Assertions
  a_rstval: assert property (p_rstval)
    else $error("Reset defaults wrong");
  a_sdaod: assert property (p_sdaod)
    else $error("SDA drive not low");
  a_intod: assert property (p_intod)
    else $error("Alert drive not low");
  a_quiet: assert property (p_quiet)
    else $error("Alert without input change");
  a_rise: assert property (p_rise)
    else $error("Input change gave no alert");
  a_stay: assert property (p_stay)
    else $error("Alert cleared without cause");
  a_edge: assert property (p_edge)
    else $error("SDA moved while SCL high");
  a_sdahi: assert property (p_sdahi)
    else $error("SDA unstable in clock high");

  // Main scenarios reached
  c_rise: cover property ($rose(intOe));
  c_fall: cover property ($fell(intOe));
  c_ack: cover property ($rose(sdaOe));
endmodule // ioe_chk

bind ioe_i2c_target ioe_chk ioe_chk_i (
  .clk(clk), .rst_n(rst_n), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .intOut(intOut), .intOe(intOe)
);

// file: verif/ioe_i2c_target_bench.sv
// Bench for the expander target: bus calls with expected pin and alert.
// Assumes the checker is bound and the master model drives the link.
`timescale 1ns/1ns

module ioe_i2c_target_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] strap = 3'h5; // Held for the whole run
  logic [15:0] ext = 16'h0000;
  logic scl, mOe, sdaOut, sdaOe, intOut, intOe, ok;
  logic [15:0] ioOut, ioOe;
  logic [7:0] rd;
  int errors = 0;
  int n_compared = 0;
  // Open-drain SDA and pins driven or left to the outside
  wire sda = !(mOe || (sdaOe && !sdaOut));
  wire [15:0] ioIn = (ioOe & ioOut) | (~ioOe & ext);

  ioe_i2c_target ioe_i2c_target_i (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .scl(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectPins(strap), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe), .intOut(intOut), .intOe(intOe)
  );
  ioe_mst ioe_mst_i (.scl(scl), .sdaOe(mOe), .sda(sda));

  // System clock
  always #5 clk = ~clk;

  // Compare and report
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt();
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    ioe_mst_i.start();
    ioe_mst_i.send({4'h4, strap, 1'b0}, 1'b0, ok);
    ioe_mst_i.send(cmd, 1'b0, ok);
    ioe_mst_i.send(d, 1'b0, ok);
    check({15'h0, ok}, 16'h1);
    ioe_mst_i.stop();
    wt();
  endtask
  task automatic rdp(input logic [7:0] cmd, output logic [7:0] d);
    ioe_mst_i.start();
    ioe_mst_i.send({4'h4, strap, 1'b0}, 1'b0, ok);
    ioe_mst_i.send(cmd, 1'b0, ok);
    ioe_mst_i.start();
    ioe_mst_i.send({4'h4, strap, 1'b1}, 1'b0, ok);
    ioe_mst_i.recv(1'b1, d);
    ioe_mst_i.stop();
    wt();
  endtask
  task automatic probe(input logic [7:0] a, input logic fake);
    ioe_mst_i.start();
    ioe_mst_i.send(a, fake, ok);
    ioe_mst_i.stop();
    wt();
  endtask
  task automatic pins(input logic [15:0] v);
    @(posedge clk);
    #1 ext = v;
    wt();
  endtask
  task automatic stop_test();
    $display("Mismatches %0d, compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #500000;
    errors++;
    stop_test();
  end

  // Test sequence
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    wt();
    check(ioOe, 16'h0000);
    check(ioOut, 16'hFFFF);
    check({15'h0, intOe}, 16'h0);
    for (int a = 0; a < 8; a++) begin
      probe({4'h4, a[2:0], 1'b0}, 1'b0);
      check({15'h0, ok}, {15'h0, a[2:0] == strap});
    end
    probe(8'h00, 1'b0);
    check({15'h0, ok}, 16'h0);
    wr(8'h02, 8'hA5);
    wr(8'h06, 8'h00);
    check(ioOe, 16'h00FF);
    check(ioIn, 16'h00A5);
    check({15'h0, intOe}, 16'h0);
    rdp(8'h00, rd);
    check({8'h0, rd}, 16'h00A5);
    pins(16'h0100);
    check({15'h0, intOe}, 16'h1);
    pins(16'h0000);
    check({15'h0, intOe}, 16'h0);
    pins(16'h0300);
    rdp(8'h00, rd);
    check({15'h0, intOe}, 16'h1);
    rdp(8'h01, rd);
    check({8'h0, rd}, 16'h0003);
    check({15'h0, intOe}, 16'h0);
    pins(16'h0200);
    check({15'h0, intOe}, 16'h1);
    probe(8'h60, 1'b1);
    check({15'h0, intOe}, 16'h1);
    rdp(8'h01, rd);
    wr(8'h06, 8'hFF);
    check({15'h0, intOe}, 16'h1);
    rdp(8'h00, rd);
    check({8'h0, rd}, 16'h0000);
    check({15'h0, intOe}, 16'h0);
    pins(16'h0201);
    probe(8'h61, 1'b1);
    check({15'h0, intOe}, 16'h0);
    wr(8'h02, 8'hFF);
    pins(16'h0200);
    probe(8'h61, 1'b1);
    check({15'h0, intOe}, 16'h1);
    #1 rst_n = 1'b0;
    wt();
    rst_n = 1'b1;
    wt();
    check(ioOe, 16'h0000);
    check({15'h0, intOe}, 16'h0);
    stop_test();
  end
endmodule // ioe_i2c_target_bench
